// ---- common/scrs_defs.vh ----
`ifndef SCRS_DEFS_VH
`define SCRS_DEFS_VH

// Register indices; the byte address is four times the index
`define SCRS_IDX_TX_DATA 16'hFE07
`define SCRS_IDX_RX_STATUS 16'hFE08
`define SCRS_IDX_RX_DATA 16'hFE09
`define SCRS_IDX_LINE_CTRL 16'hFE0A
`define SCRS_IDX_MODE 16'hFE0C
`define SCRS_IDX_IRQ_STATUS 16'hFE0D
`define SCRS_IDX_IRQ_MASK 16'hFE0E
`define SCRS_BYTE_ADDR(idx) {idx, 2'b00}

// Reset values
`define SCRS_RST_TX_DATA 8'h00
`define SCRS_RST_RX_STATUS 8'h00
`define SCRS_RST_RX_DATA 8'h00
`define SCRS_RST_LINE_CTRL 8'h21
`define SCRS_RST_MODE 8'h00
`define SCRS_RST_IRQ 8'h00

// Receive status fields
`define SCRS_ST_NINTH 7
`define SCRS_ST_FINAL 5
`define SCRS_ST_CHKERR 4
`define SCRS_ST_FULL 3
`define SCRS_ST_EMPTY 2
`define SCRS_ST_OVR 1
`define SCRS_ST_PAR 0

// Line control fields
`define SCRS_LC_IO 5
`define SCRS_LC_IOD 4
`define SCRS_LC_CLKLVL 1
`define SCRS_LC_CLKOFF 0

// Mode fields
`define SCRS_MD_SYNC 0
`define SCRS_MD_NINE 1
`define SCRS_MD_LRC 2
`define SCRS_MD_SEC 3

// Interrupt status fields
`define SCRS_IRQ_RXAVAIL 0
`define SCRS_IRQ_RECEIVE_ERROR_INTERRUPT 1
`define SCRS_IRQ_CHKERR 2

// Check values
`define SCRS_CRC_INIT 16'hFFFF
`define SCRS_CRC_POLY 16'h1021
`define SCRS_CRC_RESIDUE 16'h1D0F
`define SCRS_LRC_RESIDUE 8'h00

// Character timing in card clock periods
`define SCRS_ETU_CLKS 372

`endif

// ---- core/scrs_receive_status.v ----
`timescale 1ns/10ps
`include "scrs_defs.vh"

// Summary of operation
// - Sync nine-bit mode captures the I/O level on the ninth card clock rise.
// - Flagged final byte compares accumulated CRC, or LRC in LRC mode, with residue; mismatch flags error.
// - Read-only check error bit reads one after a CRC or LRC mismatch.
// - Read-only full bit is set whenever the receive FIFO holds its maximum.
// - Read-only empty bit exists and never raises a receive interrupt.
// - Byte arriving on a full FIFO sets overrun; firmware read clears it.
// - While overrun stands, further received bytes are discarded.
// - Overrun raises the receive error interrupt.
// - Parity error sets a flag, cleared by read, and raises receive error interrupt.
// - Received bytes queue in a FIFO read through the eight-bit data register.
module scrs_receive_status #(
  parameter RX_DEPTH = 8,
  parameter RX_AW = 3,
  parameter TX_DEPTH = 8,
  parameter TX_AW = 3,
  parameter ETU_CLKS = `SCRS_ETU_CLKS
) (
  // Clock and reset
  input wire REF_CLK,
  input wire RESET_N,
  // Avalon-MM slave
  input wire [17:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [3:0] AVS_BYTEENABLE,
  input wire [31:0] AVS_WRITEDATA,
  output wire [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  // Interrupt
  output wire IRQ,
  // Card link
  input wire CARD_CLK_IN,
  input wire CARD_IO_IN,
  input wire SECONDARY_CARD_IO_IN,
  output wire CARD_IO_OUT,
  output wire CARD_IO_OE,
  output wire CARD_CLK_LEVEL,
  output wire CARD_CLK_STOP,
  // Transmit byte stream toward the transmitter
  output wire [7:0] TX_DATA,
  output wire TX_VALID,
  input wire TX_READY
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_BITS = 4'b0100;
  localparam ST_STOP = 4'b1000;

  // CRC over one byte, most significant bit first
  function [15:0] crc_byte;
    input [15:0] crc;
    input [7:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc ^ {data, 8'h00};
      for (i = 0; i < 8; i = i + 1)
        c = c[15] ? ({c[14:0], 1'b0} ^ `SCRS_CRC_POLY) : {c[14:0], 1'b0};
      crc_byte = c;
    end
  endfunction

  // Address match for one register index
  function hit;
    input [17:0] addr;
    input [15:0] idx;
    begin
      hit = (addr == `SCRS_BYTE_ADDR(idx));
    end
  endfunction

  // Two-flop synchronisers for clock, I/O and secondary I/O
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  reg clk_prev_q;
  always @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      // Idle levels: both io lines high, card clock low, so no false edge or start
      sync1_q <= 3'h6;
      sync2_q <= 3'h6;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {SECONDARY_CARD_IO_IN, CARD_IO_IN, CARD_CLK_IN};
      sync2_q <= sync1_q;
      clk_prev_q <= sync2_q[0];
    end
  end

  // Registers
  reg [7:0] line_ctrl_q;
  reg [7:0] mode_q;
  reg [7:0] irq_st_q;
  reg [7:0] irq_mask_q;
  reg final_q;
  reg chkerr_q;
  reg ovr_q;
  reg par_q;
  reg ninth_q;
  reg irq_q;
  reg wait_q;
  reg io_oe_q;
  reg [31:0] rdata_q;

  wire clk_rise = sync2_q[0] & ~clk_prev_q;
  wire io_s = mode_q[`SCRS_MD_SEC] ? sync2_q[2] : sync2_q[1];
  wire sync_mode = mode_q[`SCRS_MD_SYNC];
  wire nine_bit_format_select = mode_q[`SCRS_MD_NINE];

  // Bus access is taken on the second cycle of a request
  wire req = AVS_READ | AVS_WRITE;
  wire take = req & ~wait_q;
  wire wr = take & AVS_WRITE & AVS_BYTEENABLE[0];
  wire rd = take & AVS_READ;
  wire rd_status = rd & hit(AVS_ADDRESS, `SCRS_IDX_RX_STATUS);
  wire rd_rxdata = rd & hit(AVS_ADDRESS, `SCRS_IDX_RX_DATA);
  wire wr_txdata = wr & hit(AVS_ADDRESS, `SCRS_IDX_TX_DATA);
  wire wr_mode = wr & hit(AVS_ADDRESS, `SCRS_IDX_MODE);

  // Receiver: sync shifter or framed character receiver
  reg [3:0] st_q;
  reg [15:0] etu_q;
  reg [3:0] bit_q;
  reg [8:0] shift_q;
  reg done_q;
  reg [7:0] byte_q;
  reg perr_q;
  always @(posedge REF_CLK)
  begin
    if (!RESET_N || wr_mode)
    begin
      st_q <= ST_IDLE;
      etu_q <= 16'h0000;
      bit_q <= 4'h0;
      shift_q <= 9'h000;
      done_q <= 1'b0;
      byte_q <= 8'h00;
      perr_q <= 1'b0;
      ninth_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      perr_q <= 1'b0;
      if (sync_mode)
      begin
        if (clk_rise)
        begin
          shift_q <= {io_s, shift_q[8:1]};
          if (bit_q == 4'h8 && nine_bit_format_select)
          begin
            ninth_q <= io_s;
            bit_q <= 4'h0;
          end
          else if (bit_q == 4'h7)
          begin
            done_q <= 1'b1;
            byte_q <= {io_s, shift_q[8:2]};
            bit_q <= nine_bit_format_select ? 4'h8 : 4'h0;
          end
          else
            bit_q <= bit_q + 4'h1;
        end
      end
      else
      begin
        case (st_q)
          ST_IDLE:
          begin
            if (!io_s)
            begin
              st_q <= ST_START;
              etu_q <= 16'h0000;
            end
          end
          ST_START:
          begin
            if (clk_rise)
            begin
              etu_q <= etu_q + 16'h0001;
              if (etu_q == ETU_CLKS / 2)
              begin
                etu_q <= 16'h0000;
                bit_q <= 4'h0;
                st_q <= io_s ? ST_IDLE : ST_BITS;
              end
            end
          end
          ST_BITS:
          begin
            if (clk_rise)
            begin
              etu_q <= etu_q + 16'h0001;
              if (etu_q == ETU_CLKS - 1)
              begin
                etu_q <= 16'h0000;
                shift_q <= {io_s, shift_q[8:1]};
                bit_q <= bit_q + 4'h1;
                if (bit_q == 4'h8)
                begin
                  done_q <= 1'b1;
                  byte_q <= shift_q[8:1];
                  // even parity over data and parity bit
                  perr_q <= ^{io_s, shift_q[8:1]};
                  st_q <= ST_STOP;
                end
              end
            end
          end
          ST_STOP:
          begin
            if (io_s)
              st_q <= ST_IDLE;
          end
          default:
            st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Receive FIFO
  reg [7:0] rx_mem_q [0:RX_DEPTH-1];
  reg [RX_AW-1:0] rx_wp_q;
  reg [RX_AW-1:0] rx_rp_q;
  reg [RX_AW:0] rx_cnt_q;
  wire rx_full = (rx_cnt_q == RX_DEPTH);
  wire rx_empty = (rx_cnt_q == {(RX_AW+1){1'b0}});
  wire ovr_evt = done_q & rx_full;
  wire push = done_q & ~rx_full & ~ovr_q;
  wire pop = rd_rxdata & ~rx_empty;
  always @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      rx_wp_q <= {RX_AW{1'b0}};
      rx_rp_q <= {RX_AW{1'b0}};
      rx_cnt_q <= {(RX_AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        rx_mem_q[rx_wp_q] <= byte_q;
        rx_wp_q <= (rx_wp_q == RX_DEPTH - 1) ? {RX_AW{1'b0}} : rx_wp_q + 1'b1;
      end
      if (pop)
        rx_rp_q <= (rx_rp_q == RX_DEPTH - 1) ? {RX_AW{1'b0}} : rx_rp_q + 1'b1;
      if (push && !pop)
        rx_cnt_q <= rx_cnt_q + 1'b1;
      else if (pop && !push)
        rx_cnt_q <= rx_cnt_q - 1'b1;
    end
  end

  // Transmit FIFO feeding the transmitter stream
  reg [7:0] tx_mem_q [0:TX_DEPTH-1];
  reg [TX_AW-1:0] tx_wp_q;
  reg [TX_AW-1:0] tx_rp_q;
  reg [TX_AW:0] tx_cnt_q;
  reg [7:0] tx_out_q;
  reg tx_vld_q;
  wire tx_take = tx_vld_q & TX_READY;
  wire tx_load = (tx_cnt_q != {(TX_AW+1){1'b0}}) & (~tx_vld_q | TX_READY);
  // write appends one byte; dropped when full
  wire tx_push = wr_txdata & (tx_cnt_q != TX_DEPTH);
  always @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      tx_wp_q <= {TX_AW{1'b0}};
      tx_rp_q <= {TX_AW{1'b0}};
      tx_cnt_q <= {(TX_AW+1){1'b0}};
      tx_out_q <= `SCRS_RST_TX_DATA;
      tx_vld_q <= 1'b0;
    end
    else
    begin
      if (tx_push)
      begin
        tx_mem_q[tx_wp_q] <= AVS_WRITEDATA[7:0];
        tx_wp_q <= (tx_wp_q == TX_DEPTH - 1) ? {TX_AW{1'b0}} : tx_wp_q + 1'b1;
      end
      if (tx_load)
      begin
        tx_out_q <= tx_mem_q[tx_rp_q];
        tx_rp_q <= (tx_rp_q == TX_DEPTH - 1) ? {TX_AW{1'b0}} : tx_rp_q + 1'b1;
        tx_vld_q <= 1'b1;
      end
      else if (tx_take)
        tx_vld_q <= 1'b0;
      if (tx_push && !tx_load)
        tx_cnt_q <= tx_cnt_q + 1'b1;
      else if (tx_load && !tx_push)
        tx_cnt_q <= tx_cnt_q - 1'b1;
    end
  end

  // Block check accumulation and final byte test
  reg [15:0] crc_q;
  reg [7:0] lrc_q;
  wire [15:0] crc_nx = crc_byte(crc_q, byte_q);
  wire [7:0] lrc_nx = lrc_q ^ byte_q;
  wire final_done = done_q & final_q;
  wire chk_bad = mode_q[`SCRS_MD_LRC] ? (lrc_nx != `SCRS_LRC_RESIDUE) : (crc_nx != `SCRS_CRC_RESIDUE);
  wire chk_evt = final_done & chk_bad;
  always @(posedge REF_CLK)
  begin
    if (!RESET_N || wr_mode || final_done)
    begin
      crc_q <= `SCRS_CRC_INIT;
      lrc_q <= 8'h00;
    end
    else if (done_q)
    begin
      crc_q <= crc_nx;
      lrc_q <= lrc_nx;
    end
  end

  // Status flags; a new event wins over the read clear
  always @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      final_q <= 1'b0;
      chkerr_q <= 1'b0;
      ovr_q <= 1'b0;
      par_q <= 1'b0;
    end
    else
    begin
      if (wr && hit(AVS_ADDRESS, `SCRS_IDX_RX_STATUS))
        final_q <= AVS_WRITEDATA[`SCRS_ST_FINAL];
      else if (final_done)
        final_q <= 1'b0;
      // check error stays until next good block or a mode write
      if (chk_evt)
        chkerr_q <= 1'b1;
      else if (final_done || wr_mode)
        chkerr_q <= 1'b0;
      if (ovr_evt)
        ovr_q <= 1'b1;
      else if (rd_status)
        ovr_q <= 1'b0;
      // parity flag set, cleared by read
      if (perr_q)
        par_q <= 1'b1;
      else if (rd_status)
        par_q <= 1'b0;
    end
  end

  // Interrupt status, mask and output
  wire [7:0] irq_evt;
  // empty is not an interrupt source
  // overrun and parity raise receive error
  assign irq_evt = {5'h00, chk_evt, ovr_evt | perr_q, push};
  wire wr_irq_st = wr & hit(AVS_ADDRESS, `SCRS_IDX_IRQ_STATUS);
  always @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      irq_st_q <= `SCRS_RST_IRQ;
      irq_mask_q <= `SCRS_RST_IRQ;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_st_q <= irq_evt | (irq_st_q & ~(wr_irq_st ? AVS_WRITEDATA[7:0] : 8'h00));
      if (wr && hit(AVS_ADDRESS, `SCRS_IDX_IRQ_MASK))
        irq_mask_q <= AVS_WRITEDATA[7:0];
      irq_q <= |(irq_st_q & irq_mask_q);
    end
  end

  // Control registers
  always @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      line_ctrl_q <= `SCRS_RST_LINE_CTRL;
      mode_q <= `SCRS_RST_MODE;
      io_oe_q <= 1'b1; // Line control resets with the io pin as output
    end
    else
    begin
      // Registered drive enable, high while the io direction bit is clear
      io_oe_q <= ~line_ctrl_q[`SCRS_LC_IOD];
      if (wr && hit(AVS_ADDRESS, `SCRS_IDX_LINE_CTRL))
        line_ctrl_q <= AVS_WRITEDATA[7:0];
      if (wr_mode)
        mode_q <= {4'h0, AVS_WRITEDATA[3:0]};
    end
  end

  // Read data mux, sampled on the first request cycle
  reg [7:0] rmux;
  always @*
  begin
    rmux = 8'h00;
    if (hit(AVS_ADDRESS, `SCRS_IDX_RX_STATUS))
      rmux = {ninth_q, 1'b0, final_q, chkerr_q, rx_full, rx_empty, ovr_q, par_q};
    else if (hit(AVS_ADDRESS, `SCRS_IDX_RX_DATA))
      rmux = rx_empty ? `SCRS_RST_RX_DATA : rx_mem_q[rx_rp_q];
    else if (hit(AVS_ADDRESS, `SCRS_IDX_LINE_CTRL))
      rmux = {line_ctrl_q[7:6], io_s, line_ctrl_q[4:0]};
    else if (hit(AVS_ADDRESS, `SCRS_IDX_MODE))
      rmux = mode_q;
    else if (hit(AVS_ADDRESS, `SCRS_IDX_IRQ_STATUS))
      rmux = irq_st_q;
    else if (hit(AVS_ADDRESS, `SCRS_IDX_IRQ_MASK))
      rmux = irq_mask_q;
  end

  // One wait cycle per access
  always @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q <= ~(req & wait_q);
      if (AVS_READ && wait_q) // Writes leave the last read data standing
        rdata_q <= {24'h000000, rmux};
    end
  end

  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign IRQ = irq_q;
  assign CARD_IO_OUT = line_ctrl_q[`SCRS_LC_IO];
  assign CARD_IO_OE = io_oe_q;
  assign CARD_CLK_LEVEL = line_ctrl_q[`SCRS_LC_CLKLVL];
  assign CARD_CLK_STOP = line_ctrl_q[`SCRS_LC_CLKOFF];
  assign TX_DATA = tx_out_q;
  assign TX_VALID = tx_vld_q;

endmodule // scrs_receive_status

// ---- verification/scrs_card.sv ----
`timescale 1ns/10ps
// Card side of the link: io with pull-up, clock only within frames
module scrs_card (
  // Card link
  output logic card_clk,
  output logic card_io
);
  // Idle: clock stopped low, io released to the pull-up level
  initial
  begin
    card_clk = 1'b0;
    card_io = 1'b1;
  end
  // Send n bits LSB first, each held for per clock rises; async adds stop time
  task automatic send(input logic [9:0] f, input int n, input int per);
    #7;
    for (int i = 0; i < n * per + (per > 1 ? 2 * per : 0); i++)
    begin
      card_io = (i < n * per) ? f[i / per] : 1'b1;
      #160 card_clk = 1'b1;
      #160 card_clk = 1'b0;
    end
    card_io = 1'b1;
    #640;
  endtask
endmodule // scrs_card

// ---- verification/scrs_receive_status_chk.sv ----
`timescale 1ns/10ps
module scrs_receive_status_chk (
  // Clock and reset
  input wire REF_CLK,
  input wire RESET_N,
  // Avalon-MM slave
  input wire [17:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [3:0] AVS_BYTEENABLE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  // Interrupt, card side and transmit stream
  input wire IRQ,
  input wire CARD_IO_OUT,
  input wire CARD_IO_OE,
  input wire CARD_CLK_LEVEL,
  input wire CARD_CLK_STOP,
  input wire [7:0] TX_DATA,
  input wire TX_VALID,
  input wire TX_READY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  logic [7:0] mask_q;
  logic [7:0] lc_q;
  // Write taken, and addresses that answer
  wire take = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  wire take_lc = take && (AVS_ADDRESS == 18'h3F828);
  wire mapped = AVS_ADDRESS >= 18'h3F81C && AVS_ADDRESS <= 18'h3F838 && AVS_ADDRESS[1:0] == 2'h0
    && AVS_ADDRESS != 18'h3F82C;
  // Shadow of mask and line control, so the outputs can be judged
  always @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      mask_q <= 8'h00;
      lc_q <= 8'h21;
    end
    else if (take && AVS_ADDRESS == 18'h3F838)
      mask_q <= AVS_WRITEDATA[7:0];
    else if (take_lc)
      lc_q <= AVS_WRITEDATA[7:0];
  end
  wait_one_a: assert property ($rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("waitrequest not low for one cycle");
  idle_wait_a: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
    else $error("waitrequest low with no request");
  read_data_a: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000
    && (mapped || AVS_READDATA == 32'h00000000)) else $error("read data out of range");
  rdata_hold_a: assert property (!AVS_READ ##1 !AVS_READ |-> $stable(AVS_READDATA))
    else $error("read data moved without a read");
  irq_mask_a: assert property (mask_q == 8'h00 |=> !IRQ)
    else $error("interrupt high while fully masked");
  irq_cause_a: assert property ($rose(IRQ) |-> $past(mask_q) != 8'h00)
    else $error("interrupt rose with no enabled source");
  tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("transmit byte not held");
  line_ctrl_a: assert property (!$past(take_lc) |-> CARD_CLK_STOP == lc_q[0] && CARD_IO_OUT == lc_q[5]
    && CARD_CLK_LEVEL == lc_q[1] && CARD_IO_OE == !lc_q[4]) else $error("card pins disagree with line control");
  cover property (take && AVS_ADDRESS == 18'h3F838);
  cover property ($rose(IRQ));
  cover property (TX_VALID && TX_READY);
endmodule // scrs_receive_status_chk
bind scrs_receive_status scrs_receive_status_chk u_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .IRQ(IRQ), .CARD_IO_OUT(CARD_IO_OUT), .CARD_IO_OE(CARD_IO_OE), .CARD_CLK_LEVEL(CARD_CLK_LEVEL),
  .CARD_CLK_STOP(CARD_CLK_STOP),
  .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY));

// ---- verification/scrs_receive_status_tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module scrs_receive_status_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, tx_ready = 1'b0, io_block = 1'b0;
  logic [17:0] avs_address = 18'h00000;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] q;
  wire [31:0] avs_readdata;
  wire [7:0] tx_data;
  wire avs_waitrequest, irq, io_out, io_oe, card_clk, card_drv, tx_valid;
  wire io_line = (io_oe ? io_out : 1'b1) & card_drv;
  int err_count = 0, samples_checked = 0;
  localparam logic [17:0] A_TX = 18'h3F81C, A_ST = 18'h3F820, A_RX = 18'h3F824, A_LC = 18'h3F828;
  localparam logic [17:0] A_MD = 18'h3F830, A_IS = 18'h3F834, A_IM = 18'h3F838;
  // Clock at 25 MHz
  always #20 ref_clk = ~ref_clk;
  scrs_card card (.card_clk(card_clk), .card_io(card_drv));
  scrs_receive_status #(.ETU_CLKS(8)) dut (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq), .CARD_CLK_IN(card_clk),
    .CARD_IO_IN(io_line | io_block), .SECONDARY_CARD_IO_IN(io_line), .CARD_IO_OUT(io_out), .CARD_IO_OE(io_oe),
    .CARD_CLK_LEVEL(), .CARD_CLK_STOP(), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready));
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [17:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Read and compare the masked low byte
  task automatic rdm(input logic [17:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(q[7:0] & m, e)
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    #2000000;
    err_count++;
    report_and_stop;
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdm(A_LC, 8'hFF, 8'h21);
    rdm(18'h3F840, 8'hFF, 8'h00);
    bus(1'b1, A_LC, 8'h22);
    rdm(A_LC, 8'hFF, 8'h22);
    bus(1'b1, A_LC, 8'h21);
    bus(1'b1, A_IM, 8'h07);
    bus(1'b1, A_MD, 8'h01);
    rdm(A_ST, 8'h1F, 8'h04);
    `CHK(irq, 1'b0)
    card.send(10'h0A5, 8, 1);
    `CHK(irq, 1'b1)
    rdm(A_ST, 8'h1F, 8'h00);
    rdm(A_RX, 8'hFF, 8'hA5);
    rdm(A_ST, 8'h1F, 8'h04);
    bus(1'b1, A_IS, 8'h07);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    for (int i = 0; i < 8; i++) card.send(10'h010 + 10'(i), 8, 1);
    rdm(A_ST, 8'h0F, 8'h08);
    card.send(10'h018, 8, 1);
    rdm(A_IS, 8'h02, 8'h02);
    rdm(A_RX, 8'hFF, 8'h10);
    // Room in the FIFO again, but the standing overrun drops this byte
    card.send(10'h019, 8, 1);
    rdm(A_ST, 8'h0F, 8'h02);
    rdm(A_ST, 8'h02, 8'h00);
    for (int i = 1; i < 8; i++) rdm(A_RX, 8'hFF, 8'h10 + 8'(i));
    rdm(A_ST, 8'h0C, 8'h04);
    bus(1'b1, A_IS, 8'h07);
    bus(1'b1, A_MD, 8'h03);
    card.send(10'h1C3, 9, 1);
    rdm(A_ST, 8'h80, 8'h80);
    rdm(A_RX, 8'hFF, 8'hC3);
    card.send(10'h03C, 9, 1);
    rdm(A_ST, 8'h80, 8'h00);
    rdm(A_RX, 8'hFF, 8'h3C);
    // Secondary line carries the data while the primary is held high
    io_block <= 1'b1;
    bus(1'b1, A_MD, 8'h0B);
    card.send(10'h15A, 9, 1);
    rdm(A_ST, 8'h80, 8'h80);
    rdm(A_RX, 8'hFF, 8'h5A);
    io_block <= 1'b0;
    bus(1'b1, A_MD, 8'h05);
    card.send(10'h05A, 8, 1);
    bus(1'b1, A_ST, 8'h20);
    card.send(10'h05A, 8, 1);
    rdm(A_ST, 8'h30, 8'h00);
    bus(1'b1, A_ST, 8'h20);
    card.send(10'h033, 8, 1);
    rdm(A_ST, 8'h10, 8'h10);
    rdm(A_IS, 8'h04, 8'h04);
    bus(1'b1, A_MD, 8'h01);
    rdm(A_ST, 8'h10, 8'h00);
    bus(1'b1, A_ST, 8'h20);
    card.send(10'h000, 8, 1);
    // One zero byte leaves 16'hE1F0, not the residue
    rdm(A_ST, 8'h10, 8'h10);
    // Two zero bytes bring the check exactly to 16'h1D0F
    card.send(10'h000, 8, 1);
    bus(1'b1, A_ST, 8'h20);
    card.send(10'h000, 8, 1);
    rdm(A_ST, 8'h30, 8'h00);
    repeat (6) bus(1'b0, A_RX, 8'h00);
    bus(1'b1, A_IS, 8'h07);
    bus(1'b1, A_IM, 8'h00);
    bus(1'b1, A_MD, 8'h00);
    card.send({1'b1, 8'h96, 1'b0}, 10, 8);
    rdm(A_ST, 8'h01, 8'h01);
    rdm(A_ST, 8'h01, 8'h00);
    rdm(A_IS, 8'h02, 8'h02);
    `CHK(irq, 1'b0)
    bus(1'b1, A_IM, 8'h02);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    card.send({1'b0, 8'h69, 1'b0}, 10, 8);
    rdm(A_ST, 8'h01, 8'h00);
    // Transmit bytes wait while the consumer stalls
    bus(1'b1, A_TX, 8'h3C);
    bus(1'b1, A_TX, 8'hC5);
    repeat (3) @(posedge ref_clk);
    `CHK(tx_valid, 1'b1)
    `CHK(tx_data, 8'h3C)
    tx_ready <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      while ((tx_valid && tx_ready) !== 1'b1) @(posedge ref_clk);
      `CHK(tx_data, i ? 8'hC5 : 8'h3C)
    end
    tx_ready <= 1'b0;
    report_and_stop;
  end
endmodule // scrs_receive_status_tb
